// ---- hdl/rtp_pkg.sv ----
// Purpose: shared constants and types for the readout timing and PROM control block
// Assumes: 50 MHz reference clock, synchronous active-high reset
// Notes: pulse and debounce counts derived from times in ms; tick count from the clock ratio
`default_nettype none

package rtp_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SYS_CLK_HZ = 32_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / SYS_CLK_HZ;
  localparam int unsigned TICK_W = 11;

  localparam int unsigned TB_W = 12;
  localparam int unsigned STROBE_BIT = 5;
  localparam int unsigned PROG_PHASE_LSB = 3;
  localparam int unsigned RECALL_PHASE_LSB = 6;
  localparam logic [TB_W-1:0] TB_RESET = 12'h000;

  localparam int unsigned ADDR_W = 11;
  localparam int unsigned BANK_BIT = 10;
  localparam int unsigned RAMP_LSB = 3;
  localparam logic [ADDR_W-1:0] LAST_WORD = 11'h7ff;
  localparam logic [7:0] LAST_PASS = 8'hff;

  localparam int unsigned PULSE_MS = 400;
  localparam int unsigned PULSE_CYCLES = PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_MS = 100;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_W = 25;

  localparam logic [3:0] SEQ_IDLE = 4'h0;
  localparam int unsigned BUF_DEPTH = 2;

  // three-level select/write pin of each PROM
  typedef enum logic [1:0] {
    RTP_LVL_OUTPUT = 2'b00,
    RTP_LVL_TRISTATE = 2'b01,
    RTP_LVL_INPUT = 2'b10
  } rtp_level_t;

  typedef enum logic [2:0] {
    RTP_IDLE = 3'b000,
    RTP_WAIT = 3'b001,
    RTP_PULSE = 3'b011,
    RTP_NEXT = 3'b010,
    RTP_DONE = 3'b110
  } rtp_state_t;

  typedef struct packed {
    rtp_level_t [1:0] level;
    logic [1:0] program_pin;
  } rtp_prom_ctl_t;

  localparam rtp_prom_ctl_t PROM_CTL_RESET = '{level: '{RTP_LVL_TRISTATE, RTP_LVL_TRISTATE},
                                               program_pin: 2'b00};

endpackage : rtp_pkg

`default_nettype wire

// ---- hdl/rtp_readout_timing.sv ----
// Purpose: timebase, two latched timing sequences, PROM programming and copy debounce
// Assumes: inputs synchronous to REF_CLK_IN; SRST_IN synchronous, active high
// Notes: program and debounce times are top parameters so a bench may shorten them
`default_nettype none

module rtp_readout_timing
  import rtp_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES,
  parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  input wire logic PROG_SYNC_IN,
  input wire logic RECALL_SYNC_IN,
  input wire logic PROM_FLOAT_CONTROL_IN,
  input wire logic PROM_WRITE_CONTROL_IN,
  input wire logic PROM_PROGRAM_PULSE_N_IN,
  input wire logic [ADDR_W-1:0] RECALL_ADDR_IN,
  input wire logic [7:0] PROM_DATA_IN,
  input wire logic [7:0] REC_DATA_IN,
  input wire logic REC_VALID_IN,
  input wire logic COPY_SWITCH_IN,
  input wire logic ERROR_IN,
  input wire logic SCAN_MODE_IN,
  output logic [TB_W-1:0] TIMEBASE_OUT,
  output logic [3:0] PROG_SEQ_OUT,
  output logic [3:0] RECALL_SEQ_OUT,
  output logic [3:0] PROG_GATED_OUT,
  output logic [3:0] RECALL_GATED_OUT,
  output rtp_prom_ctl_t PROM_CTL_OUT,
  output logic [ADDR_W-1:0] PROM_ADDR_OUT,
  output logic [7:0] PROM_DATA_OUT,
  output logic PROM_DATA_OE_OUT,
  output logic [7:0] READ_DATA_OUT,
  output logic REC_READY_OUT,
  output logic PROG_BUSY_OUT,
  output logic PROG_DONE_OUT,
  output logic [7:0] PROG_PASS_OUT,
  output logic COPY_REQ_OUT
);

  function automatic logic [3:0] rtp_phase_decode(input logic [1:0] phase);
    rtp_phase_decode = 4'h1 << phase;
  endfunction : rtp_phase_decode

  // timebase
  logic [TICK_W-1:0] tick_cnt;
  logic [TB_W-1:0] timebase_counter;
  logic strobe_prev;
  logic sequence_sync_flop;
  logic [3:0] program_sequence_latch;
  logic [3:0] recall_sequence_latch;

  wire tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
  wire sequence_strobe_tap = timebase_counter[STROBE_BIT];
  wire strobe_fall = strobe_prev & ~sequence_strobe_tap;
  wire any_sync = PROG_SYNC_IN | RECALL_SYNC_IN;
  wire prog_latch_en = sequence_sync_flop & PROG_SYNC_IN;
  wire recall_latch_en = sequence_sync_flop & RECALL_SYNC_IN;
  wire [3:0] prog_phase = rtp_phase_decode(timebase_counter[PROG_PHASE_LSB +: 2]);
  wire [3:0] recall_phase = rtp_phase_decode(timebase_counter[RECALL_PHASE_LSB +: 2]);
  wire [3:0] prog_gated = program_sequence_latch & {4{PROG_SYNC_IN}};
  wire [3:0] recall_gated = recall_sequence_latch & {4{RECALL_SYNC_IN}};

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      tick_cnt <= '0;
      timebase_counter <= TB_RESET;
      strobe_prev <= 1'b0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (tick) begin
        timebase_counter <= timebase_counter + 1'b1;
      end
      strobe_prev <= sequence_strobe_tap;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN || !any_sync) begin
      sequence_sync_flop <= 1'b0;
    end else if (strobe_fall) begin
      sequence_sync_flop <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      program_sequence_latch <= SEQ_IDLE;
      recall_sequence_latch <= SEQ_IDLE;
      PROG_GATED_OUT <= SEQ_IDLE;
      RECALL_GATED_OUT <= SEQ_IDLE;
    end else begin
      if (prog_latch_en) begin
        program_sequence_latch <= prog_phase;
      end
      if (recall_latch_en) begin
        recall_sequence_latch <= recall_phase;
      end
      PROG_GATED_OUT <= prog_gated;
      RECALL_GATED_OUT <= recall_gated;
    end
  end

  assign TIMEBASE_OUT = timebase_counter;
  assign PROG_SEQ_OUT = program_sequence_latch;
  assign RECALL_SEQ_OUT = recall_sequence_latch;

  // two-entry buffer for recorder data
  logic [7:0] buf_mem [BUF_DEPTH];
  logic buf_wr;
  logic buf_rd;
  logic [1:0] buf_cnt;
  logic pop;

  wire buf_valid = (buf_cnt != 2'd0);
  wire push = REC_VALID_IN & REC_READY_OUT;
  wire [1:0] next_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      buf_wr <= 1'b0;
      buf_rd <= 1'b0;
      buf_cnt <= 2'd0;
      REC_READY_OUT <= 1'b0;
    end else begin
      if (push) begin
        buf_mem[buf_wr] <= REC_DATA_IN;
        buf_wr <= ~buf_wr;
      end
      if (pop) begin
        buf_rd <= ~buf_rd;
      end
      buf_cnt <= next_buf_cnt;
      REC_READY_OUT <= (next_buf_cnt != 2'(BUF_DEPTH));
    end
  end

  // programming engine
  rtp_state_t state;
  rtp_state_t next_state;
  logic [ADDR_W-1:0] prog_addr;
  logic [7:0] pass_cnt;
  logic [7:0] prog_word;
  logic [TIMER_W-1:0] pulse_timer;

  wire pulse_end = (pulse_timer == TIMER_W'(PULSE_LEN - 1));
  wire word_last = (prog_addr == LAST_WORD);
  wire pass_last = (pass_cnt == LAST_PASS);
  wire engine_on = (state != RTP_IDLE) && (state != RTP_DONE);

  always_comb begin
    next_state = state;
    pop = 1'b0;
    case (state)
      RTP_IDLE: begin
        if (prog_gated[0]) begin
          next_state = RTP_WAIT;
        end
      end
      RTP_WAIT: begin
        if (buf_valid) begin
          next_state = RTP_PULSE;
        end
      end
      RTP_PULSE: begin
        if (pulse_end) begin
          next_state = RTP_NEXT;
          pop = 1'b1;
        end
      end
      RTP_NEXT: begin
        next_state = (word_last && pass_last) ? RTP_DONE : RTP_WAIT;
      end
      RTP_DONE: begin
        next_state = RTP_DONE;
      end
      default: begin
        next_state = RTP_IDLE;
      end
    endcase
    if (!PROG_SYNC_IN) begin
      next_state = RTP_IDLE;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      state <= RTP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN || state == RTP_IDLE) begin
      prog_addr <= '0;
      pass_cnt <= 8'h00;
      prog_word <= 8'h00;
      pulse_timer <= '0;
    end else begin
      if (state == RTP_WAIT) begin
        prog_word <= buf_mem[buf_rd];
        pulse_timer <= '0;
      end
      if (state == RTP_PULSE && !pulse_end) begin
        pulse_timer <= pulse_timer + 1'b1;
      end
      if (state == RTP_NEXT) begin
        prog_addr <= prog_addr + 1'b1;
        if (word_last && !pass_last) begin
          pass_cnt <= pass_cnt + 1'b1;
        end
      end
    end
  end

  // PROM pin control
  wire [ADDR_W-1:0] eff_addr = engine_on ? prog_addr : RECALL_ADDR_IN;
  wire bank = eff_addr[BANK_BIT];
  wire write_mode = PROM_WRITE_CONTROL_IN | engine_on;
  wire pulse_n = PROM_PROGRAM_PULSE_N_IN & (state != RTP_PULSE);
  rtp_prom_ctl_t next_ctl;

  always_comb begin
    next_ctl = PROM_CTL_RESET;
    if (!PROM_FLOAT_CONTROL_IN) begin
      next_ctl.level[bank] = write_mode ? RTP_LVL_INPUT : RTP_LVL_OUTPUT;
      next_ctl.program_pin[bank] = ~pulse_n;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      PROM_CTL_OUT <= PROM_CTL_RESET;
      PROM_ADDR_OUT <= '0;
      PROM_DATA_OUT <= 8'h00;
      PROM_DATA_OE_OUT <= 1'b0;
      READ_DATA_OUT <= 8'h00;
      PROG_BUSY_OUT <= 1'b0;
      PROG_DONE_OUT <= 1'b0;
      PROG_PASS_OUT <= 8'h00;
    end else begin
      PROM_CTL_OUT <= next_ctl;
      PROM_ADDR_OUT <= eff_addr;
      if (PROM_FLOAT_CONTROL_IN) begin
        PROM_DATA_OUT <= eff_addr[ADDR_W-1:RAMP_LSB];
        PROM_DATA_OE_OUT <= 1'b1;
      end else begin
        PROM_DATA_OUT <= prog_word;
        PROM_DATA_OE_OUT <= write_mode;
      end
      READ_DATA_OUT <= PROM_DATA_IN;
      PROG_BUSY_OUT <= engine_on;
      PROG_DONE_OUT <= (state == RTP_DONE);
      PROG_PASS_OUT <= pass_cnt;
    end
  end

  // copy switch one-shot
  logic copy_prev;
  logic [TIMER_W-1:0] debounce_timer;

  wire copy_blocked = ERROR_IN | SCAN_MODE_IN | PROG_SYNC_IN | engine_on;
  wire copy_rise = COPY_SWITCH_IN & ~copy_prev;
  wire copy_fire = copy_rise & ~copy_blocked & (debounce_timer == '0);

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      copy_prev <= 1'b0;
      debounce_timer <= '0;
      COPY_REQ_OUT <= 1'b0;
    end else begin
      copy_prev <= COPY_SWITCH_IN;
      COPY_REQ_OUT <= copy_fire;
      if (copy_fire) begin
        debounce_timer <= TIMER_W'(DEBOUNCE_LEN - 1);
      end else if (debounce_timer != '0) begin
        debounce_timer <= debounce_timer - 1'b1;
      end
    end
  end

endmodule : rtp_readout_timing

`default_nettype wire

// ---- bench/rtp_props.sv ----
// Purpose: port checks for the readout timing block
// Assumes: bench sets PULSE_LEN to 8
// Notes: bound to the top by the line at the foot
`default_nettype none
module rtp_props
  import rtp_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  input wire logic PROG_SYNC_IN,
  input wire logic RECALL_SYNC_IN,
  input wire logic PROM_FLOAT_CONTROL_IN,
  input wire logic PROM_WRITE_CONTROL_IN,
  input wire logic ERROR_IN,
  input wire logic [TB_W-1:0] TIMEBASE_OUT,
  input wire logic [3:0] PROG_SEQ_OUT,
  input wire logic [3:0] RECALL_SEQ_OUT,
  input wire logic [3:0] PROG_GATED_OUT,
  input wire logic [3:0] RECALL_GATED_OUT,
  input wire rtp_prom_ctl_t PROM_CTL_OUT,
  input wire logic [ADDR_W-1:0] PROM_ADDR_OUT,
  input wire logic [7:0] PROM_DATA_OUT,
  input wire logic PROM_DATA_OE_OUT,
  input wire logic COPY_REQ_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (SRST_IN);
  wire logic sel = PROM_ADDR_OUT[BANK_BIT];
  chk_tb_count: assert property (TIMEBASE_OUT != $past(TIMEBASE_OUT)
    |-> TIMEBASE_OUT == $past(TIMEBASE_OUT) + 12'h001) else $error("timebase step");
  chk_gated_drop: assert property (!PROG_SYNC_IN |=> PROG_GATED_OUT == 4'h0)
    else $error("gated not dropped");
  chk_latch_hold: assert property (!PROG_SYNC_IN && !RECALL_SYNC_IN
    |=> $stable(PROG_SEQ_OUT) && $stable(RECALL_SEQ_OUT)) else $error("latch moved");
  chk_gated_and: assert property (RECALL_GATED_OUT ==
    ($past(RECALL_SEQ_OUT) & {4{$past(RECALL_SYNC_IN)}})) else $error("gated wrong");
  chk_float_ramp: assert property ($past(PROM_FLOAT_CONTROL_IN) |-> PROM_DATA_OE_OUT
    && PROM_DATA_OUT == PROM_ADDR_OUT[BANK_BIT:RAMP_LSB]
    && PROM_CTL_OUT.level == {RTP_LVL_TRISTATE, RTP_LVL_TRISTATE}) else $error("ramp");
  chk_bank_other: assert property (!$past(PROM_FLOAT_CONTROL_IN)
    |-> PROM_CTL_OUT.level[!sel] == RTP_LVL_TRISTATE) else $error("other bank on");
  chk_write_sel: assert property ($past(PROM_WRITE_CONTROL_IN && !PROM_FLOAT_CONTROL_IN)
    |-> PROM_CTL_OUT.level[sel] == RTP_LVL_INPUT) else $error("no write level");
  chk_pulse_bank: assert property (|PROM_CTL_OUT.program_pin |->
    !PROM_CTL_OUT.program_pin[!sel]) else $error("pulse on wrong bank");
  chk_copy_block: assert property (COPY_REQ_OUT |-> !$past(ERROR_IN)
    && !$past(PROG_SYNC_IN) ##1 !COPY_REQ_OUT) else $error("copy not blocked");
endmodule : rtp_props
bind rtp_readout_timing rtp_props u_props (.*);
`default_nettype wire

// ---- bench/rtp_prom_pair.sv ----
// Purpose: pair of byte-wide UV PROMs at the memory pins
// Assumes: 2048 words, erased to ff
// Notes: released data lines change every cycle, no pull
`default_nettype none
module rtp_prom_pair
  import rtp_pkg::*;
(
  input wire logic clk_in,
  input wire rtp_prom_ctl_t ctl_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [2048];
  logic [7:0] last = 8'h00;
  logic [1:0] pin_d = 2'b00;
  wire logic bank = addr_in[BANK_BIT];
  wire logic wr_lvl = ctl_in.level[bank] == RTP_LVL_INPUT;
  initial foreach (mem[i]) mem[i] = 8'hff;
  always @(posedge clk_in) begin
    pin_d <= ctl_in.program_pin;
    last <= last + 8'h01;
    if (wr_lvl && ctl_in.program_pin[bank] && !pin_d[bank]) mem[addr_in] <= data_in;
  end
  assign data_out = ctl_in.level[bank] == RTP_LVL_OUTPUT ? mem[addr_in] : ~last;
endmodule : rtp_prom_pair
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for the readout timing block
// Assumes: short pulse and debounce counts
// Notes: first sequence strobe comes about 100k cycles in
`default_nettype none
module testbench
  import rtp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, ps, rs, flt, wr, pn, vld, rdy, sw, err, scan, oe, busy, done, creq;
  logic [10:0] ra, pa;
  logic [7:0] pin, wd, pdo, rd, pass;
  logic [11:0] tb;
  logic [11:0] tb_m = 12'h040;
  logic [3:0] pq, rq, pg, rg, n;
  rtp_prom_ctl_t ctl;
  int error_cnt = 0;
  int n_tests = 0;
  int cnt;
  logic [7:0] q[$];
  rtp_readout_timing #(.PULSE_LEN(8), .DEBOUNCE_LEN(4)) uut (
    .REF_CLK_IN(clk), .SRST_IN(rst), .PROG_SYNC_IN(ps), .RECALL_SYNC_IN(rs),
    .PROM_FLOAT_CONTROL_IN(flt), .PROM_WRITE_CONTROL_IN(wr), .PROM_PROGRAM_PULSE_N_IN(pn),
    .RECALL_ADDR_IN(ra), .PROM_DATA_IN(pin), .REC_DATA_IN(wd), .REC_VALID_IN(vld),
    .COPY_SWITCH_IN(sw), .ERROR_IN(err), .SCAN_MODE_IN(scan), .TIMEBASE_OUT(tb),
    .PROG_SEQ_OUT(pq), .RECALL_SEQ_OUT(rq), .PROG_GATED_OUT(pg), .RECALL_GATED_OUT(rg),
    .PROM_CTL_OUT(ctl), .PROM_ADDR_OUT(pa), .PROM_DATA_OUT(pdo), .PROM_DATA_OE_OUT(oe),
    .READ_DATA_OUT(rd), .REC_READY_OUT(rdy), .PROG_BUSY_OUT(busy), .PROG_DONE_OUT(done),
    .PROG_PASS_OUT(pass), .COPY_REQ_OUT(creq));
  rtp_prom_pair prom (.clk_in(clk), .ctl_in(ctl), .addr_in(pa), .data_in(pdo), .data_out(pin));
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : step
  task automatic push(input logic [7:0] w);
    logic took;
    wd = w;
    vld = 1'b1;
    cnt = 0;
    do begin
      took = rdy;
      step(1);
      cnt++;
    end while (took !== 1'b1 && cnt < 99);
    if (took !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : push
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst, ps, rs, flt, wr, vld, sw, err, scan} = 9'h100;
    pn = 1'b1;
    ra = 11'h000;
    wd = 8'h00;
    cnt = $urandom(26831);
    step(11);
    chk(ctl, PROM_CTL_RESET);
    step(1);
    rst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      ra = 11'($urandom);
      flt = 1'($urandom);
      wr = 1'($urandom);
      step(3);
      if (flt) begin
        chk({oe, pdo}, {1'b1, ra[10:3]});
        chk(ctl, {RTP_LVL_TRISTATE, RTP_LVL_TRISTATE, 2'b00});
      end else begin
        chk(ctl.level[ra[10]], wr ? RTP_LVL_INPUT : RTP_LVL_OUTPUT);
        chk(ctl.level[!ra[10]], RTP_LVL_TRISTATE);
      end
    end
    flt = 1'b0;
    wr = 1'b0;
    for (int i = 0; i < 4; i++) begin
      err = (i == 0);
      scan = (i == 1);
      ps = (i == 3);
      sw = 1'b1;
      n = 4'h0;
      repeat (8) begin
        step(1);
        n = n + 4'(creq);
      end
      sw = 1'b0;
      step(8);
      chk(n, i == 2);
    end
    ps = 1'b1;
    rs = 1'b1;
    cnt = 0;
    while (busy !== 1'b1 && cnt < 110000) begin
      step(1);
      cnt++;
    end
    if (cnt >= 110000) begin
      error_cnt++;
      tally_and_finish();
    end
    chk(tb, tb_m);
    chk({pq, rq}, {4'h1 << tb_m[4:3], 4'h1 << tb_m[7:6]});
    chk({pg, rg}, {pq, rq});
    for (int i = 0; i < 4; i++) begin
      q.push_back(8'($urandom));
      push(q[i]);
    end
    vld = 1'b0;
    step(60);
    chk({done, pass}, 9'h000);
    ps = 1'b0;
    rs = 1'b0;
    step(2);
    chk({pg, rg, busy}, 9'h000);
    chk({pq, rq}, {4'h1 << tb_m[4:3], 4'h1 << tb_m[7:6]});
    for (int i = 0; i < 4; i++) begin
      ra = 11'(i);
      step(4);
      chk(rd, q[i]);
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
